// [logic/serial_eeprom_pkg.sv]
package serial_eeprom_pkg;
  // ==========================================================================
  // Clock and timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int TWR_MS = 10;
  localparam int PROG_CYCLES = TWR_MS * 1000000 / CLK_PERIOD_NS;
  localparam int SCL_PERIOD_NS = 10000;
  localparam int SCL_QTR_CYCLES = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
  // ==========================================================================
  // Addressing and array geometry
  localparam logic [6:0] DEV_ADDR = 7'h50;
  localparam logic RW_READ = 1'h1;
  localparam logic RW_WRITE = 1'h0;
  localparam int ADDR_W = 7;
  localparam int DEPTH = 128;
  localparam int PAGE = 8;
  localparam int PAGE_BITS = 3;
  // ==========================================================================
  // Bit and pulse counts
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [7:0] REVERT_PULSES = 8'h80;
endpackage

// [logic/two_wire_if.sv]
interface two_wire_if;
  logic scl;
  logic transmit_only_clock;
  logic host_sda_out;
  logic host_sda_oe;
  logic dev_sda_out;
  logic dev_sda_oe;
  logic sda;

  // Open-drain data line: low while any enabled driver pulls it low.
  assign sda = ~((host_sda_oe & ~host_sda_out) | (dev_sda_oe & ~dev_sda_out));

  modport host (
    output scl,
    output transmit_only_clock,
    output host_sda_out,
    output host_sda_oe,
    input sda
  );
  modport device (
    input scl,
    input transmit_only_clock,
    output dev_sda_out,
    output dev_sda_oe,
    input sda
  );
endinterface

// [logic/eeprom_slave.sv]
module eeprom_slave #(
  parameter int PROG_CYCLES = serial_eeprom_pkg::PROG_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Two-wire link
  two_wire_if.device bus,
  // Status
  output logic mode_bidir,
  output logic mode_transition,
  output logic prog_busy
);
  localparam int CW = $clog2(PROG_CYCLES + 1);

  typedef enum logic [2:0] {
    mode_to = 3'h1,
    mode_trans = 3'h2,
    mode_bi = 3'h4
  } mode_t;

  typedef enum logic [6:0] {
    e_idle = 7'h01,
    e_ctrl = 7'h02,
    e_word = 7'h04,
    e_wdata = 7'h08,
    e_ack = 7'h10,
    e_rdata = 7'h20,
    e_mack = 7'h40
  } eng_t;

  typedef struct packed {
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic [2:0] tclk_s;
    mode_t mode;
    eng_t eng;
    eng_t after_ack;
    logic [7:0] shift;
    logic [3:0] bitn;
    logic [6:0] ptr;
    logic mack_ok;
    logic wp_bad;
    logic [7:0] pulses;
    logic [6:0] saddr;
    logic [3:0] sbit;
    logic [CW-1:0] busy_cnt;
    logic busy;
    logic sda_oe;
    logic [serial_eeprom_pkg::PAGE-1:0] vld;
    logic [serial_eeprom_pkg::PAGE-1:0][7:0] pbuf;
    logic [serial_eeprom_pkg::DEPTH-1:0][7:0] mem;
  } state_t;

  state_t r;
  state_t next_r;
  logic scl_hi;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic tclk_rise;

  // ==========================================================================
  // Edge and condition detection on synchronised pins
  assign scl_hi = r.scl_s[1] & r.scl_s[2];
  assign scl_rise = r.scl_s[1] & ~r.scl_s[2];
  assign scl_fall = ~r.scl_s[1] & r.scl_s[2];
  assign start_c = scl_hi & r.sda_s[2] & ~r.sda_s[1];
  assign stop_c = scl_hi & ~r.sda_s[2] & r.sda_s[1];
  assign tclk_rise = r.tclk_s[1] & ~r.tclk_s[2];

  // ==========================================================================
  // Next state
  always_comb begin
    next_r = r;
    next_r.scl_s = {r.scl_s[1:0], bus.scl};
    next_r.sda_s = {r.sda_s[1:0], bus.sda};
    next_r.tclk_s = {r.tclk_s[1:0], bus.transmit_only_clock};

    // The write timer runs on its own; the pulse clock cannot cut it short.
    if (r.busy) begin
      if (r.busy_cnt == CW'(PROG_CYCLES - 1)) begin
        next_r.busy = 1'b0;
      end else begin
        next_r.busy_cnt = r.busy_cnt + 1'b1;
      end
    end

    case (r.mode)
      mode_to: begin
        if (scl_fall) begin
          next_r.mode = mode_trans;
          next_r.pulses = '0;
          next_r.sda_oe = 1'b0;
        end else if (tclk_rise) begin
          if (r.sbit == serial_eeprom_pkg::BYTE_BITS) begin
            next_r.sda_oe = 1'b0;
            next_r.sbit = '0;
            next_r.saddr = r.saddr + 1'b1;
          end else begin
            next_r.sda_oe = ~r.mem[r.saddr][3'h7 - r.sbit[2:0]];
            next_r.sbit = r.sbit + 1'b1;
          end
        end
      end
      mode_trans: begin
        if (scl_fall) begin
          next_r.pulses = '0;
        end else if (tclk_rise && r.pulses != serial_eeprom_pkg::REVERT_PULSES) begin
          next_r.pulses = r.pulses + 1'b1;
        end
        if (r.pulses == serial_eeprom_pkg::REVERT_PULSES && scl_hi) begin
          next_r.mode = mode_to;
          next_r.saddr = '0;
          next_r.sbit = '0;
          next_r.eng = e_idle;
          next_r.sda_oe = 1'b0;
        end
      end
      mode_bi: begin
        next_r.mode = mode_bi;
      end
      default: next_r.mode = mode_to;
    endcase

    // ========================================================================
    // Bus engine
    if (start_c) begin
      next_r.eng = e_ctrl;
      next_r.bitn = '0;
      next_r.vld = '0;
      next_r.wp_bad = 1'b0;
      if (r.mode != mode_to) begin
        next_r.sda_oe = 1'b0;
      end
    end else if (stop_c) begin
      next_r.eng = e_idle;
      next_r.vld = '0;
      if (r.mode != mode_to) begin
        next_r.sda_oe = 1'b0;
      end
      // Only the buffered bytes are programmed, all in one go.
      if (|r.vld && !r.wp_bad && !r.busy) begin
        for (int i = 0; i < serial_eeprom_pkg::PAGE; i++) begin
          if (r.vld[i]) begin
            next_r.mem[{r.ptr[6:3], 3'(i)}] = r.pbuf[i];
          end
        end
        next_r.busy = 1'b1;
        next_r.busy_cnt = '0;
      end
    end else if (r.mode != mode_to) begin
      if (!r.tclk_s[1] && r.eng != e_idle) begin
        next_r.wp_bad = 1'b1;
      end
      if (scl_rise) begin
        case (r.eng)
          e_ctrl, e_word, e_wdata: begin
            next_r.shift = {r.shift[6:0], r.sda_s[1]};
            next_r.bitn = r.bitn + 1'b1;
          end
          e_rdata: next_r.bitn = r.bitn + 1'b1;
          e_mack: next_r.mack_ok = ~r.sda_s[1];
          default: next_r.bitn = r.bitn;
        endcase
      end else if (scl_fall) begin
        case (r.eng)
          e_ctrl: begin
            if (r.bitn == serial_eeprom_pkg::BYTE_BITS) begin
              next_r.bitn = '0;
              next_r.eng = e_idle;
              if (r.shift[7:1] == serial_eeprom_pkg::DEV_ADDR) begin
                if (r.mode == mode_trans) begin
                  next_r.mode = mode_bi;
                end
                if (!r.busy) begin
                  next_r.sda_oe = 1'b1;
                  next_r.eng = e_ack;
                  next_r.after_ack = (r.shift[0] == serial_eeprom_pkg::RW_READ) ? e_rdata : e_word;
                end
              end
            end
          end
          e_word: begin
            if (r.bitn == serial_eeprom_pkg::BYTE_BITS) begin
              next_r.bitn = '0;
              next_r.ptr = r.shift[6:0];
              next_r.vld = '0;
              next_r.sda_oe = 1'b1;
              next_r.eng = e_ack;
              next_r.after_ack = e_wdata;
            end
          end
          e_wdata: begin
            if (r.bitn == serial_eeprom_pkg::BYTE_BITS) begin
              next_r.bitn = '0;
              next_r.pbuf[r.ptr[2:0]] = r.shift;
              next_r.vld[r.ptr[2:0]] = 1'b1;
              next_r.ptr = {r.ptr[6:3], 3'(r.ptr[2:0] + 3'h1)};
              next_r.sda_oe = 1'b1;
              next_r.eng = e_ack;
              next_r.after_ack = e_wdata;
            end
          end
          e_ack: begin
            next_r.sda_oe = 1'b0;
            next_r.eng = r.after_ack;
            next_r.bitn = '0;
            if (r.after_ack == e_rdata) begin
              next_r.shift = r.mem[r.ptr];
              next_r.sda_oe = ~r.mem[r.ptr][7];
            end
          end
          e_rdata: begin
            if (r.bitn == serial_eeprom_pkg::BYTE_BITS) begin
              next_r.sda_oe = 1'b0;
              next_r.eng = e_mack;
              next_r.ptr = r.ptr + 1'b1;
            end else begin
              next_r.shift = {r.shift[6:0], 1'b0};
              next_r.sda_oe = ~r.shift[6];
            end
          end
          e_mack: begin
            next_r.bitn = '0;
            if (r.mack_ok) begin
              next_r.eng = e_rdata;
              next_r.shift = r.mem[r.ptr];
              next_r.sda_oe = ~r.mem[r.ptr][7];
            end else begin
              next_r.eng = e_idle;
              next_r.sda_oe = 1'b0;
            end
          end
          default: next_r.eng = e_idle;
        endcase
      end
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r <= '0;
      r.scl_s <= 3'h7;
      r.sda_s <= 3'h7;
      r.tclk_s <= 3'h7;
      r.mode <= mode_to;
      r.eng <= e_idle;
      r.after_ack <= e_idle;
    end else begin
      r <= next_r;
    end
  end

  assign bus.dev_sda_out = 1'b0;
  assign bus.dev_sda_oe = r.sda_oe;
  assign mode_bidir = r.mode[2];
  assign mode_transition = r.mode[1];
  assign prog_busy = r.busy;
endmodule

// [logic/bus_master.sv]
module bus_master #(
  parameter int QTR_CYCLES = serial_eeprom_pkg::SCL_QTR_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Command port
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_read,
  input wire logic [6:0] cmd_addr,
  input wire logic [7:0] cmd_data,
  output logic done,
  output logic nack,
  // Read data
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [7:0] rd_data,
  // Pulse clock control
  input wire logic toc_run,
  input wire logic write_protect,
  // Two-wire link
  two_wire_if.host bus
);
  localparam int DW = $clog2(QTR_CYCLES + 1);

  typedef enum logic [3:0] {
    h_idle = 4'h1,
    h_start = 4'h2,
    h_byte = 4'h4,
    h_stop = 4'h8
  } hst_t;

  typedef struct packed {
    logic [1:0] sda_s;
    hst_t st;
    logic [1:0] q;
    logic [DW-1:0] div;
    logic [2:0] step;
    logic [3:0] bitn;
    logic [7:0] shift;
    logic rd;
    logic [6:0] addr;
    logic [7:0] data;
    logic scl;
    logic sda_oe;
    logic tclk;
    logic nack;
    logic done;
    logic rdy;
    logic [1:0] fq_vld;
    logic [1:0][7:0] fq_data;
  } state_t;

  state_t r;
  state_t next_r;
  logic tick;
  logic rx;
  logic stall;

  function automatic logic [7:0] tx_byte(input logic [2:0] step, input logic [6:0] addr, input logic [7:0] data);
    case (step)
      3'h0: tx_byte = {serial_eeprom_pkg::DEV_ADDR, serial_eeprom_pkg::RW_WRITE};
      3'h1: tx_byte = {1'b0, addr};
      3'h3: tx_byte = {serial_eeprom_pkg::DEV_ADDR, serial_eeprom_pkg::RW_READ};
      default: tx_byte = data;
    endcase
  endfunction

  assign tick = r.div == DW'(QTR_CYCLES - 1);
  assign rx = r.step == 3'h4;
  // A full read buffer holds the bus in the acknowledge slot, so no byte is lost.
  assign stall = r.st == h_byte && r.q == 2'h1 && r.bitn == serial_eeprom_pkg::BYTE_BITS && rx && r.fq_vld[1];

  // ==========================================================================
  // Next state
  always_comb begin
    next_r = r;
    next_r.sda_s = {r.sda_s[0], bus.sda};
    next_r.done = 1'b0;
    next_r.div = tick ? '0 : r.div + 1'b1;
    if (rd_ready && r.fq_vld[0]) begin
      next_r.fq_data[0] = r.fq_data[1];
      next_r.fq_vld = {1'b0, r.fq_vld[1]};
    end
    if (r.st == h_idle && toc_run) begin
      next_r.tclk = tick ? ~r.tclk : r.tclk;
    end else begin
      next_r.tclk = ~write_protect;
    end
    if (tick && !stall && r.st != h_idle) begin
      next_r.q = r.q + 1'b1;
    end

    case (r.st)
      h_idle: begin
        next_r.rdy = 1'b1;
        if (cmd_valid && r.rdy && r.sda_s[1] && r.scl) begin
          next_r.rdy = 1'b0;
          next_r.rd = cmd_read;
          next_r.addr = cmd_addr;
          next_r.data = cmd_data;
          next_r.nack = 1'b0;
          next_r.step = '0;
          next_r.q = '0;
          next_r.div = '0;
          next_r.st = h_start;
        end
      end
      h_start: begin
        if (tick) begin
          case (r.q)
            2'h0: begin
              next_r.sda_oe = 1'b0;
              // A repeated start follows an acknowledge with the clock high, so the clock is lowered first.
              next_r.scl = r.step == 3'h0;
            end
            2'h1: next_r.scl = 1'b1;
            2'h2: next_r.sda_oe = 1'b1;
            default: begin
              next_r.scl = 1'b0;
              next_r.st = h_byte;
              next_r.bitn = '0;
              next_r.shift = tx_byte(r.step, r.addr, r.data);
            end
          endcase
        end
      end
      h_byte: begin
        if (tick && !stall) begin
          case (r.q)
            2'h0: next_r.scl = 1'b0;
            2'h1: begin
              if (r.bitn == serial_eeprom_pkg::BYTE_BITS) begin
                next_r.sda_oe = 1'b0;
                if (rx) begin
                  next_r.fq_data[next_r.fq_vld[0]] = r.shift;
                  next_r.fq_vld[next_r.fq_vld[0]] = 1'b1;
                end
              end else begin
                next_r.sda_oe = ~rx & ~r.shift[7];
              end
            end
            2'h2: next_r.scl = 1'b1;
            default: begin
              if (r.bitn != serial_eeprom_pkg::BYTE_BITS) begin
                next_r.shift = {r.shift[6:0], r.sda_s[1]};
                next_r.bitn = r.bitn + 1'b1;
              end else if (!rx && r.sda_s[1]) begin
                next_r.nack = 1'b1;
                next_r.st = h_stop;
              end else begin
                next_r.bitn = '0;
                case (r.step)
                  3'h1: begin
                    next_r.step = r.rd ? 3'h3 : 3'h2;
                    next_r.st = r.rd ? h_start : h_byte;
                    next_r.shift = r.data;
                  end
                  3'h2, 3'h4: next_r.st = h_stop;
                  default: begin
                    next_r.step = r.step + 1'b1;
                    next_r.shift = tx_byte(r.step + 3'h1, r.addr, r.data);
                  end
                endcase
              end
            end
          endcase
        end
      end
      h_stop: begin
        if (tick) begin
          case (r.q)
            2'h0: next_r.scl = 1'b0;
            2'h1: next_r.sda_oe = 1'b1;
            2'h2: next_r.scl = 1'b1;
            default: begin
              next_r.sda_oe = 1'b0;
              next_r.st = h_idle;
              next_r.done = 1'b1;
            end
          endcase
        end
      end
      default: next_r.st = h_idle;
    endcase
  end

  // ==========================================================================
  // State register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r <= '0;
      r.sda_s <= 2'h3;
      r.st <= h_idle;
      r.scl <= 1'b1;
      r.tclk <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign bus.scl = r.scl;
  assign bus.transmit_only_clock = r.tclk;
  assign bus.host_sda_out = 1'b0;
  assign bus.host_sda_oe = r.sda_oe;
  assign cmd_ready = r.rdy;
  assign done = r.done;
  assign nack = r.nack;
  assign rd_valid = r.fq_vld[0];
  assign rd_data = r.fq_data[0];
endmodule

// [tb/eeprom_link_assertions.sv]
module eeprom_link_assertions #(
  parameter int PROG_CYCLES = 50
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Link wires
  input wire logic scl,
  input wire logic transmit_only_clock,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe,
  input wire logic sda,
  // Device status
  input wire logic mode_bidir,
  input wire logic mode_transition,
  input wire logic prog_busy
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int BUSY_MAX = PROG_CYCLES + 8;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // ==========================================================================
  // Mode sequencing
  property p_bidir_sticky; mode_bidir |=> mode_bidir; endproperty
  a_bidir_sticky: assert property (p_bidir_sticky) else $error("bidirectional mode left");
  property p_bidir_via_trans; $rose(mode_bidir) |-> $past(mode_transition); endproperty
  a_bidir_via_trans: assert property (p_bidir_via_trans) else $error("bidir without transition");
  property p_pulse_ignored; mode_bidir && $changed(transmit_only_clock) |=> mode_bidir && !mode_transition;
  endproperty
  a_pulse_ignored: assert property (p_pulse_ignored) else $error("pulse clock disturbed bidir");
  // ==========================================================================
  // Wire framing
  property p_start_idle; $rose(host_sda_oe) && scl |-> $past(sda) && $past(scl); endproperty
  a_start_idle: assert property (p_start_idle) else $error("start from busy bus");
  property p_stop_free; $fell(host_sda_oe) && scl |-> !dev_sda_oe; endproperty
  a_stop_free: assert property (p_stop_free) else $error("device holds data at stop");
  property p_dev_stable; mode_bidir && scl && $past(scl) |-> $stable(dev_sda_oe); endproperty
  a_dev_stable: assert property (p_dev_stable) else $error("device data moved in high");
  property p_ack_low; $rose(dev_sda_oe) && (mode_bidir || mode_transition) |-> !scl; endproperty
  a_ack_low: assert property (p_ack_low) else $error("device drive began in high");
  property p_ack_high; dev_sda_oe && $rose(scl) |-> dev_sda_oe [*8]; endproperty
  a_ack_high: assert property (p_ack_high) else $error("ack dropped in high phase");
  // ==========================================================================
  // Programming
  property p_busy_quiet; prog_busy |-> !dev_sda_oe; endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("ack while programming");
  property p_busy_hold; $rose(prog_busy) |-> prog_busy [*8]; endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("programming cut short");
  property p_busy_end; $rose(prog_busy) |-> ##[1:BUSY_MAX] !prog_busy; endproperty
  a_busy_end: assert property (p_busy_end) else $error("programming overran");
  c_bidir: cover property ($rose(mode_bidir));
  c_prog: cover property ($rose(prog_busy));
  c_ack: cover property (dev_sda_oe && $rose(scl));
endmodule

// [tb/eeprom_dual_mode_serial_slave_bench.sv]
module eeprom_dual_mode_serial_slave_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int PROG = 400;
  logic clk;
  logic rstn;
  logic host_rstn;
  int spin;
  logic cmd_valid;
  logic cmd_ready;
  logic cmd_read;
  logic [6:0] cmd_addr;
  logic [7:0] cmd_data;
  logic done;
  logic nack;
  logic rd_valid;
  logic rd_ready;
  logic [7:0] rd_data;
  logic toc_run;
  logic write_protect;
  logic mode_bidir;
  logic mode_transition;
  logic prog_busy;
  logic [7:0] got;
  int n_mismatch;
  int comparisons;
  two_wire_if link();
  eeprom_slave #(.PROG_CYCLES(PROG)) eeprom_slave_inst (.clk(clk), .rstn(rstn), .bus(link.device),
    .mode_bidir(mode_bidir), .mode_transition(mode_transition), .prog_busy(prog_busy));
  bus_master #(.QTR_CYCLES(8)) bus_master_inst (.clk(clk), .rstn(host_rstn), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .done(done),
    .nack(nack), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data), .toc_run(toc_run),
    .write_protect(write_protect), .bus(link.host));
  eeprom_link_assertions #(.PROG_CYCLES(PROG)) eeprom_link_assertions_inst (.clk(clk), .rstn(rstn),
    .scl(link.scl), .transmit_only_clock(link.transmit_only_clock), .host_sda_oe(link.host_sda_oe),
    .dev_sda_oe(link.dev_sda_oe), .sda(link.sda), .mode_bidir(mode_bidir),
    .mode_transition(mode_transition), .prog_busy(prog_busy));
  // ==========================================================================
  // Shared tasks
  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] value, input logic [7:0] expect_value);
    comparisons++;
    if (value !== expect_value) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, value, expect_value);
    end
  endtask
  // A command is held until cmd_ready is seen low, which marks the take.
  task automatic run_cmd(input logic rd, input logic [6:0] a, input logic [7:0] d);
    int n;
    n = 0;
    do @(posedge clk); while (cmd_ready !== 1'b1);
    cmd_read <= rd;
    cmd_addr <= a;
    cmd_data <= d;
    cmd_valid <= 1'b1;
    do @(posedge clk); while (cmd_ready !== 1'b0);
    cmd_valid <= 1'b0;
    do begin
      @(posedge clk);
      n++;
    end while (done !== 1'b1 && n < 6000);
    if (n >= 6000) begin
      n_mismatch++;
      $display("unexpected at %0t: done %h expected %h", $time, 1'b0, 1'b1);
    end
  endtask
  task automatic pop(output logic [7:0] v);
    int n;
    n = 0;
    rd_ready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (rd_valid !== 1'b1 && n < 100);
    v = rd_data;
    rd_ready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_prog();
    int n;
    n = 0;
    repeat (10) @(posedge clk);
    while (prog_busy !== 1'b0 && n < 600) begin
      @(posedge clk);
      n++;
    end
    check({7'h00, prog_busy}, 8'h00);
  endtask
  task automatic read_byte(input logic [6:0] a, input logic [7:0] e);
    run_cmd(1'b1, a, 8'h00);
    check({7'h00, nack}, 8'h00);
    pop(got);
    check(got, e);
  endtask
  // ==========================================================================
  // Clock, watchdog and tests
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (80000) @(posedge clk);
    n_mismatch++;
    $display("unexpected at %0t: watchdog %h expected %h", $time, 1'b1, 1'b0);
    complete_run();
  end
  initial begin
    n_mismatch = 0;
    comparisons = 0;
    rstn = 1'b0;
    host_rstn = 1'b0;
    cmd_valid = 1'b0;
    cmd_read = 1'b0;
    cmd_addr = 7'h00;
    cmd_data = 8'h00;
    rd_ready = 1'b0;
    toc_run = 1'b0;
    write_protect = 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    host_rstn <= 1'b1;
    @(posedge clk);
    check({6'h00, mode_bidir, mode_transition}, 8'h00);
    run_cmd(1'b0, 7'h12, 8'h5A);
    check({7'h00, nack}, 8'h00);
    check({6'h00, mode_bidir, mode_transition}, 8'h02);
    run_cmd(1'b0, 7'h13, 8'hC3);
    check({7'h00, nack}, 8'h01);
    wait_prog();
    read_byte(7'h12, 8'h5A);
    read_byte(7'h13, 8'h00);
    $display("test byte write and busy refusal done");
    toc_run <= 1'b1;
    repeat (300) @(posedge clk);
    toc_run <= 1'b0;
    check({6'h00, mode_bidir, mode_transition}, 8'h02);
    write_protect <= 1'b1;
    run_cmd(1'b0, 7'h20, 8'hA5);
    check({7'h00, nack}, 8'h00);
    wait_prog();
    write_protect <= 1'b0;
    read_byte(7'h20, 8'h00);
    $display("test write protect done");
    run_cmd(1'b0, 7'h21, 8'h3C);
    write_protect <= 1'b1;
    wait_prog();
    write_protect <= 1'b0;
    read_byte(7'h21, 8'h3C);
    $display("test pulse clock during programming done");
    run_cmd(1'b1, 7'h12, 8'h00);
    run_cmd(1'b1, 7'h21, 8'h00);
    check({7'h00, rd_valid}, 8'h01);
    pop(got);
    check(got, 8'h5A);
    pop(got);
    check(got, 8'h3C);
    check({7'h00, rd_valid}, 8'h00);
    $display("test read buffer fill and drain done");
    rstn <= 1'b0;
    host_rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    host_rstn <= 1'b1;
    @(posedge clk);
    check({6'h00, mode_bidir, mode_transition}, 8'h00);
    do @(posedge clk); while (cmd_ready !== 1'b1);
    cmd_read <= 1'b0;
    cmd_addr <= 7'h05;
    cmd_data <= 8'h99;
    cmd_valid <= 1'b1;
    // The master is cut off just after the start's clock fall, so no control byte follows.
    do @(posedge clk); while (mode_transition !== 1'b1);
    check({6'h00, mode_bidir, mode_transition}, 8'h01);
    cmd_valid <= 1'b0;
    host_rstn <= 1'b0;
    repeat (3) @(posedge clk);
    host_rstn <= 1'b1;
    toc_run <= 1'b1;
    spin = 0;
    do begin
      @(posedge clk);
      spin++;
    end while (mode_transition !== 1'b0 && spin < 3000);
    toc_run <= 1'b0;
    check({6'h00, mode_bidir, mode_transition}, 8'h00);
    run_cmd(1'b0, 7'h05, 8'h99);
    check({7'h00, nack}, 8'h00);
    check({6'h00, mode_bidir, mode_transition}, 8'h02);
    wait_prog();
    read_byte(7'h05, 8'h99);
    $display("test revert after second reset done");
    complete_run();
  end
endmodule
